// [rtl/asb_pkg.sv]
// Shared constants and types for the converter sequencing and result buffer block.
// Assumes one clock domain and an Avalon-MM slave with 32-bit data, word addressed.
package asb_pkg;

    // Register word indices, byte address is four times the index
    localparam logic [3:0] ADDR_CONTROL_ONE   = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_TWO   = 4'h1;
    localparam logic [3:0] ADDR_INPUT_SELECT  = 4'h2;
    localparam logic [3:0] ADDR_SCAN_LIST     = 4'h3;
    localparam logic [3:0] ADDR_STATUS        = 4'h4;
    localparam logic [3:0] ADDR_BUFFER_BASE   = 4'h8;

    // Control one fields
    localparam int CON1_SAMPLE_NOW_BIT   = 1;
    localparam int CON1_AUTO_SAMPLE_BIT  = 2;
    localparam int CON1_TRIGGER_LSB      = 5;
    localparam int CON1_ON_BIT           = 15;
    localparam logic [2:0] TRIG_INTERNAL = 3'h7;

    // Control two fields
    localparam int CON2_ALT_BIT          = 0;
    localparam int CON2_SPLIT_BIT        = 1;
    localparam int CON2_SPI_LSB          = 2;
    localparam int CON2_FILL_STATUS_BIT  = 7;
    localparam int CON2_SCAN_BIT         = 10;

    // Input select fields
    localparam int SEL_A_POS_LSB         = 16;
    localparam int SEL_A_NEG_BIT         = 23;
    localparam int SEL_B_POS_LSB         = 24;
    localparam int SEL_B_NEG_BIT         = 31;

    // Reset values
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

    // Buffer shape
    localparam int BUF_WORDS             = 16;
    localparam logic [3:0] HALF_BASE_HI  = 4'h8;

    // Conversion timing
    localparam int CONV_TIME_NS          = 48;
    localparam int CLK_PERIOD_NS         = 4;
    localparam int CONV_CYCLES           = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_TIME_NS        = 16;
    localparam int SAMPLE_CYCLES         = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10
    } asb_state_type;

    // Input choice handed to the analog front end
    typedef struct packed {
        logic [3:0] pos;
        logic       neg_is_input;
        logic       from_b;
    } asb_route_type;

    // One finished result heading for the buffer
    typedef struct packed {
        logic       valid;
        logic [3:0] slot;
        logic [9:0] data;
    } asb_write_type;

endpackage : asb_pkg

// [rtl/asb_scan_pick.sv]
// Finds the next scan-list input at or after a start index, wrapping round.
// Pure combinational; an empty list yields input 0.
`timescale 1ns/1ps
module asb_scan_pick (
    input  wire logic [15:0] mask,
    input  wire logic [3:0]  start,
    output logic      [3:0]  pick
);
    always_comb begin
        logic [4:0] idx;
        pick = 4'h0;
        idx  = 5'd0;
        for (int k = 15; k >= 0; k--) begin
            idx = 5'(start) + 5'(k);
            if (mask[idx[3:0]]) begin
                pick = idx[3:0];
            end
        end
    end
endmodule : asb_scan_pick

// [rtl/asb_result_ram.sv]
// Sixteen-word result store, one write port and one read port.
// Read data is registered; it appears one clock after the address.
`timescale 1ns/1ps
module asb_result_ram (
    input  wire logic                  mclk,
    input  wire asb_pkg::asb_write_type wr,
    input  wire logic [3:0]            rd_addr,
    output logic      [9:0]            rd_data
);
    logic [9:0] mem_q [asb_pkg::BUF_WORDS];

    always_ff @(posedge mclk) begin
        if (wr.valid) begin
            mem_q[wr.slot] <= wr.data;
        end
    end

    always_ff @(posedge mclk) begin
        rd_data <= mem_q[rd_addr];
    end
endmodule : asb_result_ram

// [rtl/asb_seq_top.sv]
// Sequencing and result-buffer control for a 10-bit successive-approximation converter.
// Assumes the analog core converts one sample per conv_start pulse and returns conv_done with data.
// Function
// - Scan enable takes mux A positive input from scan list
// - Scan converts selected inputs ascending from 0 into consecutive slots
// - Interrupt after samples-per-interrupt field plus one samples
// - After interrupt restart sequence at first selection and region base
// - Split bit clear gives one 16-word buffer, set gives two halves
// - Split mode changes only write addresses, nothing else
// - Split mode starts at 0x0, then 0x8, alternating each interrupt
// - Read-only fill status bit toggles at each interrupt
// - Alternate bit set alternates mux A and mux B per sample
// - Alternate bit clear uses mux A only
// - Mux A positive from bits 19:16, negative choice bit 23
// - Mux B positive from bits 27:24, negative choice bit 31
// - Negative select 0 connects the negative reference
// - Sixteen-bit scan mask, one bit per analog input
// - Scan with alternation advances list only on mux A samples
// - Alternation, split, count four writes four results per half
// - Auto-sample clear: sample only when software sets sample bit
// - Mux B may select two inputs as a differential source
// - Internal trigger with auto-sample repeats without software
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module asb_seq_top (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_data,
    input  wire logic        ext_trigger,
    output logic             sample_hold,
    output logic             conv_start,
    output asb_pkg::asb_route_type route,
    output logic             conversion_irq_flag
);

    logic [31:0] control_one_q;
    logic [31:0] control_two_q;
    logic [31:0] input_select_q;
    logic [15:0] scan_list_q;
    logic        buffer_fill_status_q;
    logic        irq_q;
    logic        irq_clear;
    asb_pkg::asb_state_type state_q;
    logic [7:0]  timer_q;
    logic [3:0]  count_q;
    logic [3:0]  ptr_q;
    logic        use_b_q;
    logic [3:0]  scan_idx_q;
    logic [3:0]  scan_pick;
    logic [1:0]  bus_phase_q;
    logic [9:0]  ram_rd;
    asb_pkg::asb_write_type wr;
    asb_pkg::asb_route_type route_d;
    logic        sample_done;
    logic        last_sample;

    wire logic       scan_enable          = control_two_q[asb_pkg::CON2_SCAN_BIT];
    wire logic       buffer_split_mode    = control_two_q[asb_pkg::CON2_SPLIT_BIT];
    wire logic       alternate_mux_select = control_two_q[asb_pkg::CON2_ALT_BIT];
    wire logic [3:0] samples_per_irq      = control_two_q[asb_pkg::CON2_SPI_LSB +: 4];
    wire logic       auto_sample          = control_one_q[asb_pkg::CON1_AUTO_SAMPLE_BIT];
    wire logic       sample_now           = control_one_q[asb_pkg::CON1_SAMPLE_NOW_BIT];
    wire logic [2:0] trigger_source       = control_one_q[asb_pkg::CON1_TRIGGER_LSB +: 3];
    wire logic       module_on            = control_one_q[asb_pkg::CON1_ON_BIT];
    wire logic [3:0] mux_a_positive_sel   = input_select_q[asb_pkg::SEL_A_POS_LSB +: 4];
    wire logic       mux_a_negative_sel   = input_select_q[asb_pkg::SEL_A_NEG_BIT];
    wire logic [3:0] mux_b_positive_sel   = input_select_q[asb_pkg::SEL_B_POS_LSB +: 4];
    wire logic       mux_b_negative_sel   = input_select_q[asb_pkg::SEL_B_NEG_BIT];

    // Base of the region now being filled
    function automatic logic [3:0] region_base(input logic split, input logic hi);
        return (split && hi) ? asb_pkg::HALF_BASE_HI : 4'h0;
    endfunction : region_base

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    asb_scan_pick u_pick (
        .mask  (scan_list_q),
        .start (scan_idx_q),
        .pick  (scan_pick)
    );

    asb_result_ram u_ram (
        .mclk    (mclk),
        .wr      (wr),
        .rd_addr (avs_address - asb_pkg::ADDR_BUFFER_BASE),
        .rd_data (ram_rd)
    );

    // Waitrequest is a flop, so it idles high and every request waits at least one cycle
    // Reads wait a second cycle so the registered store output can reach readdata in time
    wire logic bus_wr      = avs_write && !avs_waitrequest;
    wire logic bus_rd_done = avs_read && avs_waitrequest && bus_phase_q == 2'd1;

    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_phase_q     <= 2'd0;
            avs_waitrequest <= 1'b1;
        end else if (!avs_waitrequest) begin
            bus_phase_q     <= 2'd0;
            avs_waitrequest <= 1'b1;
        end else if (avs_write) begin
            avs_waitrequest <= 1'b0;
        end else if (avs_read) begin
            bus_phase_q     <= bus_phase_q + 2'd1;
            avs_waitrequest <= bus_phase_q != 2'd1;
        end
    end

    assign irq_clear = bus_wr && avs_address == asb_pkg::ADDR_STATUS && avs_byteenable[0] && avs_writedata[0];

    always_ff @(posedge mclk) begin
        if (rst) begin
            control_one_q  <= asb_pkg::RESET_WORD;
            control_two_q  <= asb_pkg::RESET_WORD;
            input_select_q <= asb_pkg::RESET_WORD;
            scan_list_q    <= 16'h0000;
        end else begin
            if (bus_wr && avs_address == asb_pkg::ADDR_CONTROL_ONE) begin
                control_one_q <= merge(control_one_q, avs_writedata, avs_byteenable);
            end else if (state_q == asb_pkg::ST_SAMPLE && sample_done) begin
                control_one_q[asb_pkg::CON1_SAMPLE_NOW_BIT] <= 1'b0;
            end
            if (bus_wr && avs_address == asb_pkg::ADDR_CONTROL_TWO) begin
                control_two_q <= merge(control_two_q, avs_writedata, avs_byteenable)
                                 & ~(32'h0000_0001 << asb_pkg::CON2_FILL_STATUS_BIT);
            end
            if (bus_wr && avs_address == asb_pkg::ADDR_INPUT_SELECT) begin
                input_select_q <= merge(input_select_q, avs_writedata, avs_byteenable);
            end
            if (bus_wr && avs_address == asb_pkg::ADDR_SCAN_LIST) begin
                scan_list_q <= 16'(merge({16'h0000, scan_list_q}, avs_writedata, avs_byteenable));
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_rd_done) begin
            if (avs_address >= asb_pkg::ADDR_BUFFER_BASE) begin
                avs_readdata <= 32'(ram_rd);
            end else if (avs_address == asb_pkg::ADDR_CONTROL_ONE) begin
                avs_readdata <= control_one_q;
            end else if (avs_address == asb_pkg::ADDR_CONTROL_TWO) begin
                avs_readdata <= control_two_q | (32'(buffer_fill_status_q) << asb_pkg::CON2_FILL_STATUS_BIT);
            end else if (avs_address == asb_pkg::ADDR_INPUT_SELECT) begin
                avs_readdata <= input_select_q;
            end else if (avs_address == asb_pkg::ADDR_SCAN_LIST) begin
                avs_readdata <= 32'(scan_list_q);
            end else if (avs_address == asb_pkg::ADDR_STATUS) begin
                avs_readdata <= 32'({ptr_q, count_q, 2'(state_q), irq_q});
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    // Input routing for the next sample
    always_comb begin
        route_d = '0;
        if (alternate_mux_select && use_b_q) begin
            route_d.pos          = mux_b_positive_sel;
            route_d.neg_is_input = mux_b_negative_sel;
            route_d.from_b       = 1'b1;
        end else begin
            route_d.pos          = scan_enable ? scan_pick : mux_a_positive_sel;
            route_d.neg_is_input = mux_a_negative_sel;
        end
    end

    // Sample start: software bit, or automatic restart with internal or external trigger
    wire logic start_ok = module_on && (sample_now || auto_sample);
    wire logic end_sample = (trigger_source == asb_pkg::TRIG_INTERNAL) ? (timer_q == 8'(asb_pkg::SAMPLE_CYCLES))
                          : (auto_sample ? ext_trigger : !sample_now);
    assign sample_done = end_sample;
    assign last_sample = count_q == samples_per_irq;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q     <= asb_pkg::ST_IDLE;
            timer_q     <= 8'h00;
            sample_hold <= 1'b0;
            conv_start  <= 1'b0;
            route       <= '0;
        end else begin
            conv_start <= 1'b0;
            case (state_q)
                asb_pkg::ST_IDLE: begin
                    timer_q <= 8'h00;
                    if (start_ok) begin
                        state_q     <= asb_pkg::ST_SAMPLE;
                        sample_hold <= 1'b1;
                        route       <= route_d;
                    end
                end
                asb_pkg::ST_SAMPLE: begin
                    timer_q <= timer_q + 8'h01;
                    if (end_sample) begin
                        state_q     <= asb_pkg::ST_CONV;
                        sample_hold <= 1'b0;
                        conv_start  <= 1'b1;
                    end
                end
                asb_pkg::ST_CONV: begin
                    // Core timing owned by the analog side; a stuck core stalls here
                    if (conv_done) begin
                        state_q <= asb_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= asb_pkg::ST_IDLE;
                end
            endcase
        end
    end

    wire logic result_in = state_q == asb_pkg::ST_CONV && conv_done;

    always_comb begin
        wr.valid = result_in;
        wr.slot  = ptr_q;
        wr.data  = conv_data;
    end

    // Sequence position, pointer and interrupt count
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_q              <= 4'h0;
            ptr_q                <= 4'h0;
            use_b_q              <= 1'b0;
            scan_idx_q           <= 4'h0;
            buffer_fill_status_q <= 1'b0;
        end else if (result_in) begin
            if (last_sample) begin
                count_q              <= 4'h0;
                use_b_q              <= 1'b0;
                scan_idx_q           <= 4'h0;
                buffer_fill_status_q <= ~buffer_fill_status_q;
                ptr_q                <= region_base(buffer_split_mode, ~buffer_fill_status_q);
            end else begin
                count_q <= count_q + 4'h1;
                ptr_q   <= ptr_q + 4'h1;
                use_b_q <= alternate_mux_select ? ~use_b_q : 1'b0;
                if (!(alternate_mux_select && use_b_q)) begin
                    scan_idx_q <= route.pos + 4'h1;
                end
            end
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (result_in && last_sample) begin
            irq_q <= 1'b1;
        end else if (irq_clear) begin
            irq_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            conversion_irq_flag <= 1'b0;
        end else begin
            conversion_irq_flag <= (result_in && last_sample) || (irq_q && !irq_clear);
        end
    end

    property p_irq_count;
        @(posedge mclk) disable iff (rst)
        (result_in && count_q == samples_per_irq) |=> conversion_irq_flag && count_q == 4'h0;
    endproperty
    a_irq_count: assert property (p_irq_count) else $error("irq not raised at count");

    property p_rebase;
        @(posedge mclk) disable iff (rst)
        (result_in && last_sample) |=> ptr_q == region_base(buffer_split_mode, buffer_fill_status_q);
    endproperty
    a_rebase: assert property (p_rebase) else $error("pointer not at region base");

    property p_fill_toggle;
        @(posedge mclk) disable iff (rst)
        (result_in && last_sample) |=> buffer_fill_status_q != $past(buffer_fill_status_q);
    endproperty
    a_fill_toggle: assert property (p_fill_toggle) else $error("fill status did not toggle");

    property p_alt_b;
        @(posedge mclk) disable iff (rst)
        (state_q == asb_pkg::ST_IDLE && start_ok && alternate_mux_select && use_b_q) |=> route.pos == mux_b_positive_sel;
    endproperty
    a_alt_b: assert property (p_alt_b) else $error("mux b not used");

    property p_only_a;
        @(posedge mclk) disable iff (rst)
        (state_q == asb_pkg::ST_IDLE && start_ok && !alternate_mux_select) |=> !route.from_b;
    endproperty
    a_only_a: assert property (p_only_a) else $error("mux b used without alternation");

    property p_scan_pos;
        @(posedge mclk) disable iff (rst)
        (state_q == asb_pkg::ST_IDLE && start_ok && scan_enable && !route_d.from_b) |=> scan_list_q[route.pos];
    endproperty
    a_scan_pos: assert property (p_scan_pos) else $error("scan input not in list");

    sequence s_write;
        result_in && !last_sample;
    endsequence
    property p_ptr_step;
        @(posedge mclk) disable iff (rst)
        s_write |=> ptr_q == $past(ptr_q) + 4'h1;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

    property p_manual;
        @(posedge mclk) disable iff (rst)
        (state_q == asb_pkg::ST_IDLE && !auto_sample && !sample_now) |=> state_q == asb_pkg::ST_IDLE;
    endproperty
    a_manual: assert property (p_manual) else $error("sampling started without request");

    property p_restart;
        @(posedge mclk) disable iff (rst)
        (result_in && last_sample) |=> !use_b_q && scan_idx_q == 4'h0 && count_q == 4'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("sequence did not restart");

    property p_single_base;
        @(posedge mclk) disable iff (rst)
        (result_in && last_sample && !buffer_split_mode) |=> ptr_q == 4'h0;
    endproperty
    a_single_base: assert property (p_single_base) else $error("single buffer did not return to slot 0");
endmodule : asb_seq_top

// [sim/tb.sv]
// Self-checking bench for the converter sequencing block: bus tasks, a stand-in analog core, one task per scenario.
// Assumes the result sits in readdata[9:0] and a conversion finishes only once the bench lets it.
`timescale 1ns/1ps
module tb;
    logic                   mclk            = 1'b0;
    logic                   rst             = 1'b1;
    logic [3:0]             avs_address     = 4'h0;
    logic                   avs_read        = 1'b0;
    logic                   avs_write       = 1'b0;
    logic [31:0]            avs_writedata   = 32'h0;
    logic [31:0]            avs_readdata;
    logic                   avs_waitrequest;
    logic                   conv_done       = 1'b0;
    logic [9:0]             conv_data       = 10'h0;
    logic                   sample_hold;
    logic                   conv_start;
    logic                   conversion_irq_flag;
    asb_pkg::asb_route_type route;
    asb_pkg::asb_route_type rt;
    logic [31:0]            rd;
    int                     n_fail      = 0;
    int                     checks_done = 0;
    int                     n_conv      = 0;
    int                     n_done      = 0;
    int                     limit       = 0;
    int                     pend        = 0;

    always #2 mclk = ~mclk;

    asb_seq_top i_asb_seq_top (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_done(conv_done),
        .conv_data(conv_data), .ext_trigger(1'b0), .sample_hold(sample_hold), .conv_start(conv_start),
        .route(route), .conversion_irq_flag(conversion_irq_flag));

    // Stand-in analog core: result encodes the route, so buffer contents show what was sampled.
    // Answers are held back past the limit, which freezes the sequencer in a known place.
    always @(posedge mclk) begin
        conv_done <= 1'b0;
        if (rst) begin
            n_conv <= 0;
            n_done <= 0;
            pend <= 0;
        end else if (conv_start === 1'b1) begin
            n_conv <= n_conv + 1;
            rt <= route;
            pend <= 3;
        end else if (pend > 1) begin
            pend <= pend - 1;
        end else if (pend == 1 && n_done < limit) begin
            conv_done <= 1'b1;
            conv_data <= {4'(n_done), rt.from_b, rt.neg_is_input, rt.pos};
            n_done <= n_done + 1;
            pend <= 0;
        end
    end

    function automatic logic [31:0] ew(input int c, input int b, input int n, input int p);
        return {22'h0, 4'(c), 1'(b), 1'(n), 4'(p)};
    endfunction : ew

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic timed_out(input string what);
        n_fail++;
        $display("Error at %0t: wait for %s ran out", $time, what);
        final_report();
    endtask : timed_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 50) timed_out("write");
        avs_write <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a);
        int i;
        @(posedge mclk);
        avs_address <= a;
        avs_read <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 50) timed_out("read");
        rd = avs_readdata;
        avs_read <= 1'b0;
    endtask : bus_read

    task automatic wait_irq;
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge mclk);
            if (conversion_irq_flag === 1'b1) break;
        end
        if (i == 400) timed_out("interrupt");
    endtask : wait_irq

    task automatic wait_done(input int n);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge mclk);
            if (n_done >= n) break;
        end
        if (i == 400) timed_out("conversions");
        repeat (2) @(posedge mclk);
    endtask : wait_done

    task automatic do_reset(input int lim);
        limit = lim;
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
    endtask : do_reset

    task automatic t_regs;
        do_reset(0);
        bus_read(asb_pkg::ADDR_CONTROL_ONE);
        chk(rd, asb_pkg::RESET_WORD, "control one reset");
        bus_read(asb_pkg::ADDR_CONTROL_TWO);
        chk(rd, asb_pkg::RESET_WORD, "control two reset");
        bus_read(asb_pkg::ADDR_STATUS);
        chk(rd, asb_pkg::RESET_WORD, "status reset");
        bus_write(4'h5, 32'hffff_ffff);
        bus_read(4'h5);
        chk(rd, 32'h0, "unmapped read");
        bus_write(asb_pkg::ADDR_CONTROL_TWO, 32'h0000_0080);
        bus_read(asb_pkg::ADDR_CONTROL_TWO);
        chk({31'h0, rd[7]}, 32'h0, "fill status written");
        $display("Test registers done");
    endtask : t_regs

    // Scan of inputs 0..2, three samples per interrupt, then a restart at slot 0
    task automatic t_scan;
        do_reset(5);
        bus_write(asb_pkg::ADDR_SCAN_LIST, 32'h0000_0007);
        bus_write(asb_pkg::ADDR_INPUT_SELECT, 32'h000f_0000);
        bus_write(asb_pkg::ADDR_CONTROL_TWO, 32'h0000_0408);
        bus_write(asb_pkg::ADDR_CONTROL_ONE, 32'h0000_80e4);
        wait_irq();
        chk(32'(n_done), 32'd3, "samples at interrupt");
        wait_done(5);
        for (int i = 0; i < 3; i++) begin
            bus_read(asb_pkg::ADDR_BUFFER_BASE + 4'(i));
            chk({22'h0, rd[9:0]}, (i < 2) ? ew(4'(i + 3), 0, 0, 4'(i)) : ew(2, 0, 0, 2), "scan slot");
        end
        $display("Test scan done");
    endtask : t_scan

    // Alternation into split halves, B differential; half two is unreadable, so slot 0 must survive
    task automatic t_alt_split;
        do_reset(4);
        bus_write(asb_pkg::ADDR_INPUT_SELECT, 32'h8103_0000);
        bus_write(asb_pkg::ADDR_CONTROL_TWO, 32'h0000_000f);
        bus_write(asb_pkg::ADDR_CONTROL_ONE, 32'h0000_80e4);
        wait_irq();
        wait_done(4);
        for (int i = 0; i < 4; i++) begin
            bus_read(asb_pkg::ADDR_BUFFER_BASE + 4'(i));
            chk({22'h0, rd[9:0]}, i[0] ? ew(4'(i), 1, 1, 1) : ew(4'(i), 0, 0, 3), "alt slot");
        end
        bus_read(asb_pkg::ADDR_CONTROL_TWO);
        chk({31'h0, rd[7]}, 32'h1, "fill status first");
        bus_write(asb_pkg::ADDR_STATUS, 32'h0000_0001);
        bus_read(asb_pkg::ADDR_STATUS);
        chk({31'h0, rd[0]}, 32'h0, "flag cleared");
        chk({31'h0, conversion_irq_flag}, 32'h0, "flag output cleared");
        limit = 8;
        wait_irq();
        wait_done(8);
        bus_read(asb_pkg::ADDR_BUFFER_BASE);
        chk({22'h0, rd[9:0]}, ew(0, 0, 0, 3), "lower half kept");
        bus_read(asb_pkg::ADDR_CONTROL_TWO);
        chk({31'h0, rd[7]}, 32'h0, "fill status second");
        bus_write(asb_pkg::ADDR_STATUS, 32'h0000_0001);
        limit = 12;
        wait_irq();
        wait_done(12);
        bus_read(asb_pkg::ADDR_BUFFER_BASE + 4'h3);
        chk({22'h0, rd[9:0]}, ew(11, 1, 1, 1), "lower half again");
        $display("Test alternate split done");
    endtask : t_alt_split

    // Scan with alternation: list steps only on A samples, B keeps its field
    task automatic t_scan_alt;
        do_reset(6);
        bus_write(asb_pkg::ADDR_SCAN_LIST, 32'h0000_0003);
        bus_write(asb_pkg::ADDR_INPUT_SELECT, 32'h020f_0000);
        bus_write(asb_pkg::ADDR_CONTROL_TWO, 32'h0000_040d);
        bus_write(asb_pkg::ADDR_CONTROL_ONE, 32'h0000_80e4);
        wait_done(6);
        bus_read(asb_pkg::ADDR_BUFFER_BASE);
        chk({22'h0, rd[9:0]}, ew(4, 0, 0, 0), "restart slot 0");
        bus_read(asb_pkg::ADDR_BUFFER_BASE + 4'h1);
        chk({22'h0, rd[9:0]}, ew(5, 1, 0, 2), "restart slot 1");
        bus_read(asb_pkg::ADDR_BUFFER_BASE + 4'h2);
        chk({22'h0, rd[9:0]}, ew(2, 0, 0, 1), "second list entry");
        $display("Test scan alternate done");
    endtask : t_scan_alt

    // Manual sampling: nothing until the sample bit, then one sample and no restart
    task automatic t_manual;
        do_reset(4);
        bus_write(asb_pkg::ADDR_INPUT_SELECT, 32'h0105_0000);
        bus_write(asb_pkg::ADDR_CONTROL_ONE, 32'h0000_80e0);
        repeat (30) @(posedge mclk);
        chk(32'(n_conv), 32'd0, "no sample before bit");
        chk({31'h0, sample_hold}, 32'h0, "no hold before bit");
        bus_write(asb_pkg::ADDR_CONTROL_ONE, 32'h0000_80e2);
        repeat (2) @(posedge mclk);
        chk({31'h0, sample_hold}, 32'h1, "hold after bit");
        wait_irq();
        wait_done(1);
        repeat (40) @(posedge mclk);
        chk(32'(n_conv), 32'd1, "single manual sample");
        bus_read(asb_pkg::ADDR_BUFFER_BASE);
        chk({22'h0, rd[9:0]}, ew(0, 0, 0, 5), "mux A only");
        $display("Test manual done");
    endtask : t_manual

    initial begin
        t_regs();
        t_scan();
        t_alt_split();
        t_scan_alt();
        t_manual();
        final_report();
    end
endmodule : tb
